// [rtc_defs.svh]
// rtc_defs.svh: named constants of the calendar clock and its schedulers
// assumes: included by bare name from each design module file of the block, not from the package
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// ----------------------------------------------------------------------
// clock rate and second length
// ----------------------------------------------------------------------
`define RTC_CLK_PERIOD_NS 10
`define RTC_SEC_NS        1_000_000_000

// ----------------------------------------------------------------------
// calendar field limits
// ----------------------------------------------------------------------
`define RTC_YEAR_MAX     7'h63
`define RTC_MONTH_MIN    4'h1
`define RTC_MONTH_MAX    4'hC
`define RTC_DAY_MIN      5'h01
`define RTC_DAY_MAX      5'h1F
`define RTC_HOUR_MAX     5'h17
`define RTC_MIN_MAX      6'h3B
`define RTC_SEC_MAX      6'h3B
`define RTC_BASE_YEAR    12'h7D0
`define RTC_DAYS_WEEK    12'h007

// ----------------------------------------------------------------------
// minute arithmetic
// ----------------------------------------------------------------------
`define RTC_MIN_PER_DAY  11'h5A0
`define RTC_MIN_PER_HOUR 11'h03C
`define RTC_QH_MIN       11'h00F

// ----------------------------------------------------------------------
// daylight saving, european dates
// ----------------------------------------------------------------------
`define RTC_JAN          4'h1
`define RTC_FEB          4'h2
`define RTC_MAR          4'h3
`define RTC_APR          4'h4
`define RTC_SEP          4'h9
`define RTC_OCT          4'hA
`define RTC_DEC          4'hC
`define RTC_LAST_SUN_DAY 5'h19
`define RTC_EU_SWITCH    11'h078
`define RTC_SUNDAY       3'h0

// ----------------------------------------------------------------------
// time zone limits in signed quarter hours
// ----------------------------------------------------------------------
`define RTC_TZ_LO        (-7'sh2F)
`define RTC_TZ_HI        7'sh30

`endif

// [rtc_pkg.sv]
// rtc_pkg.sv: shared types of the calendar clock
// assumes: compiled before all modules of the block
`default_nettype none

package rtc_pkg;
  // calendar date, year two digits
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
  } rtc_date_s;

  // full date and time of day
  typedef struct packed {
    rtc_date_s  date;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } rtc_time_s;

  // weekly window: day mask, start minute, stop minute or duration
  typedef struct packed {
    logic [6:0]  day_mask;
    logic [10:0] start;
    logic [10:0] stop;
  } rtc_sch_s;

  // daylight saving modes
  typedef enum logic [1:0] {
    RTC_DST_OFF,
    RTC_DST_ON,
    RTC_DST_EU,
    RTC_DST_CAL
  } rtc_dst_e;
endpackage : rtc_pkg

`default_nettype wire

// [rtc_wday.sv]
// rtc_wday.sv: weekday of a date, sunday is zero
// assumes: years 2000 to 2099, purely combinational
`include "rtc_defs.svh"
`default_nettype none

module rtc_wday
  import rtc_pkg::*;
(
  // date in
  input  wire rtc_date_s  date,
  // weekday out
  output logic [2:0]      wday
);
  logic [11:0] y;    // full year, shifted back for jan and feb
  logic [11:0] acc;  // weekday sum before modulo
  logic [11:0] t;    // month correction

  // month-offset weekday sum
  always_comb begin
    y = `RTC_BASE_YEAR + 12'(date.year);
    if (date.month < `RTC_MAR) begin
      y = y - 12'h001;
    end
    case (date.month)
      4'h2:    t = 12'h003;
      4'h3:    t = 12'h002;
      4'h4:    t = 12'h005;
      4'h6:    t = 12'h003;
      4'h7:    t = 12'h005;
      4'h8:    t = 12'h001;
      4'h9:    t = 12'h004;
      4'hA:    t = 12'h006;
      4'hB:    t = 12'h002;
      4'hC:    t = 12'h004;
      default: t = 12'h000;
    endcase
    acc = y + y / 12'h004 - y / 12'h064 + y / 12'h190 + t
          + 12'(date.day);
    wday = 3'(acc % `RTC_DAYS_WEEK);
  end
endmodule : rtc_wday

`default_nettype wire

// [rtc_date_step.sv]
// rtc_date_step.sv: next or previous calendar day
// assumes: two-digit year, leap when divisible by four
`include "rtc_defs.svh"
`default_nettype none

module rtc_date_step
  import rtc_pkg::*;
(
  // date in and direction
  input  wire rtc_date_s  cur,
  input  wire logic       back,
  // stepped date
  output rtc_date_s       nxt
);
  // days in a month
  function automatic logic [4:0] dim(logic [3:0] m, logic [6:0] yr);
    case (m)
      `RTC_FEB:            dim = (yr[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: dim = 5'h1E;
      default:             dim = `RTC_DAY_MAX;
    endcase
  endfunction : dim

  // one day forward or back with month and year carry
  always_comb begin
    nxt = cur;
    if (!back) begin
      if (cur.day >= dim(cur.month, cur.year)) begin
        nxt.day = `RTC_DAY_MIN;
        if (cur.month == `RTC_DEC) begin
          nxt.month = `RTC_JAN;
          nxt.year  = (cur.year == `RTC_YEAR_MAX) ? 7'h00 : cur.year + 7'h01;
        end else begin
          nxt.month = cur.month + 4'h1;
        end
      end else begin
        nxt.day = cur.day + 5'h01;
      end
    end else if (cur.day == `RTC_DAY_MIN) begin
      if (cur.month == `RTC_JAN) begin
        nxt.month = `RTC_DEC;
        nxt.year  = (cur.year == 7'h00) ? `RTC_YEAR_MAX : cur.year - 7'h01;
        nxt.day   = `RTC_DAY_MAX;
      end else begin
        nxt.month = cur.month - 4'h1;
        nxt.day   = dim(cur.month - 4'h1, cur.year);
      end
    end else begin
      nxt.day = cur.day - 5'h01;
    end
  end
endmodule : rtc_date_step

`default_nettype wire

// [rtc_top.sv]
// rtc_top.sv: calendar clock with daylight saving and weekly schedulers
// assumes: one clock, inputs synchronous to clk, settings held by software
//
// Functional notes
// RL1 - year 0-99, month 1-12, day 1-31
// RL2 - software writes hours 0-23, minutes/seconds 0-59
// RL3 - weekday derived from date, never written
// RL4 - saving offset counts quarter hours, added locally
// RL5 - modes 0 and 1 fix saving off/on
// RL6 - mode 2: on last March Sunday 2:00
// RL7 - mode 2: off last October Sunday 3:00
// RL8 - mode 3: calendar 15 on, 16 off
// RL9 - server UTC plus clamped zone, then saving
// RL10 - invalid clock with schedules raises warning
// RL11 - copy time from lowest-address bus master
// RL12 - test runs masked days, start plus duration
// RL13 - grid failure aborts test immediately
// RL14 - breaker closes in test only if enabled
// RL15 - starts allowed only inside inhibit window
// RL16 - override forces remote start inside window
// RL17 - bit 0 sunday, minute resolution windows
// RL18 - field write validates clock, restarts seconds
`include "rtc_defs.svh"
`default_nettype none

module rtc_top
  import rtc_pkg::*;
#(
  parameter int TICKS_PER_SEC = `RTC_SEC_NS / `RTC_CLK_PERIOD_NS,
  parameter int QH_W          = 4
) (
  // clock, reset, enable
  input  wire  logic                  clk,
  input  wire  logic                  arst_n,
  input  wire  logic                  ce,
  // software time write, standard time
  input  wire  logic                  set_we,
  input  wire  rtc_time_s             set_time,
  // network time server
  input  wire  logic                  ntp_we,
  input  wire  rtc_time_s             ntp_utc,
  input  wire  logic signed [6:0]     tz_qh,
  // controller bus and master choice
  input  wire  logic [7:0]            own_addr,
  input  wire  logic                  own_is_mains,
  input  wire  logic                  mains_seen,
  input  wire  logic [7:0]            lowest_mains_addr,
  input  wire  logic [7:0]            lowest_gen_addr,
  input  wire  logic                  bus_we,
  input  wire  rtc_time_s             bus_time,
  // daylight saving settings
  input  wire  rtc_dst_e              dst_mode,
  input  wire  logic [QH_W-1:0]       dst_qh,
  input  wire  logic                  dst_on_evt,
  input  wire  logic                  dst_off_evt,
  // backup supply
  input  wire  logic                  battery_dead,
  // schedulers: 0 test, 1 inhibit, 2 override
  input  wire  logic [2:0]            sched_en,
  input  wire  rtc_sch_s [2:0]        sched_cfg,
  input  wire  logic                  load_on_test,
  input  wire  logic                  grid_fail,
  // clock state out
  output rtc_time_s                   local_time,
  output logic [2:0]                  weekday,
  output logic                        dst_active,
  output logic                        clock_valid,
  output logic                        write_rejected,
  output logic                        is_clock_master,
  output logic                        clock_invalid_warning,
  // engine mode requests
  output logic                        test_mode,
  output logic                        generator_breaker,
  output logic                        start_inhibit,
  output logic                        remote_start
);
  localparam int TW = $clog2(TICKS_PER_SEC);

  // ----------------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------------
  rtc_date_s          std_date;      // stored standard date
  logic [10:0]        std_mod;       // stored minute of day
  logic [5:0]         std_sec;       // stored seconds
  logic [TW-1:0]      tick_cnt;      // cycles within a second
  logic               test_aborted;  // grid failed in this window
  rtc_date_s          roll_date;     // standard date plus one
  rtc_date_s          ntp_step;      // server date shifted one day
  rtc_date_s          loc_date;      // local date
  logic [10:0]        loc_mod;       // local minute of day
  logic [2:0]         std_wd;        // weekday of standard date
  logic [2:0]         loc_wd;        // weekday of local date
  logic [2:0]         win;           // scheduler windows open
  logic               master_now;    // this unit leads the bus

  // field ranges of a written time
  function automatic logic in_range(rtc_time_s t);
    in_range = t.date.year <= `RTC_YEAR_MAX                   // RL1
      && t.date.month >= `RTC_MONTH_MIN
      && t.date.month <= `RTC_MONTH_MAX
      && t.date.day >= `RTC_DAY_MIN && t.date.day <= `RTC_DAY_MAX
      && t.hour <= `RTC_HOUR_MAX && t.minute <= `RTC_MIN_MAX   // RL2
      && t.second <= `RTC_SEC_MAX;
  endfunction : in_range

  // ----------------------------------------------------------------------
  // write sources
  // ----------------------------------------------------------------------
  logic               sw_ok;         // software write accepted
  logic               bus_ok;        // bus copy accepted
  logic               ntp_ok;        // server time accepted
  logic               load;          // any accepted write
  logic signed [6:0]  tz_c;          // clamped zone
  logic signed [12:0] ntp_sum;       // server minute plus zone
  rtc_date_s          next_date;     // date to load
  logic [10:0]        next_mod;      // minute to load
  logic [5:0]         next_sec;      // second to load

  // bus master: lowest mains address, else lowest generator address
  assign master_now = mains_seen
    ? (own_is_mains && own_addr == lowest_mains_addr)       // RL11
    : (!own_is_mains && own_addr == lowest_gen_addr);

  assign sw_ok  = set_we && in_range(set_time);
  assign bus_ok = bus_we && !master_now && in_range(bus_time); // RL11
  assign ntp_ok = ntp_we && in_range(ntp_utc);
  assign load   = sw_ok || bus_ok || ntp_ok;

  // utc to standard local: clamp zone, shift minutes, carry a day
  always_comb begin
    if (tz_qh < `RTC_TZ_LO) begin
      tz_c = `RTC_TZ_LO;                                      // RL9
    end else if (tz_qh > `RTC_TZ_HI) begin
      tz_c = `RTC_TZ_HI;
    end else begin
      tz_c = tz_qh;
    end
    ntp_sum = 13'(ntp_utc.hour * `RTC_MIN_PER_HOUR)
            + 13'(ntp_utc.minute)
            + 13'(tz_c * $signed({2'b00, `RTC_QH_MIN}));      // RL9
  end

  rtc_date_step u_ntp_step (
    .cur  (ntp_utc.date),
    .back (ntp_sum < 13'sh0000),
    .nxt  (ntp_step)
  );

  // pick the write: software, then bus, then server
  always_comb begin
    next_sec  = ntp_utc.second;
    next_date = ntp_utc.date;
    next_mod  = 11'(ntp_sum);
    if (sw_ok) begin
      next_date = set_time.date;
      next_mod  = 11'(set_time.hour * `RTC_MIN_PER_HOUR)
                + 11'(set_time.minute);
      next_sec  = set_time.second;
    end else if (bus_ok) begin
      next_date = bus_time.date;
      next_mod  = 11'(bus_time.hour * `RTC_MIN_PER_HOUR)
                + 11'(bus_time.minute);
      next_sec  = bus_time.second;
    end else if (ntp_sum < 13'sh0000) begin
      next_date = ntp_step;
      next_mod  = 11'(ntp_sum + 13'(`RTC_MIN_PER_DAY));
    end else if (ntp_sum >= 13'(`RTC_MIN_PER_DAY)) begin
      next_date = ntp_step;
      next_mod  = 11'(ntp_sum - 13'(`RTC_MIN_PER_DAY));
    end
  end

  // ----------------------------------------------------------------------
  // timekeeping
  // ----------------------------------------------------------------------
  rtc_date_step u_roll (
    .cur  (std_date),
    .back (1'b0),
    .nxt  (roll_date)
  );

  // second prescaler, restarted by any accepted write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= '0;
    end else if (ce) begin
      if (load || tick_cnt == TW'(TICKS_PER_SEC - 1)) begin
        tick_cnt <= '0;                                       // RL18
      end else begin
        tick_cnt <= tick_cnt + TW'(1);
      end
    end
  end

  // standard date and time, advanced once a second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      std_date <= '{year: 7'h00, month: `RTC_JAN, day: `RTC_DAY_MIN};
      std_mod  <= '0;
      std_sec  <= '0;
    end else if (ce) begin
      if (load) begin
        std_date <= next_date;                                // RL18
        std_mod  <= next_mod;
        std_sec  <= next_sec;
      end else if (tick_cnt == TW'(TICKS_PER_SEC - 1)) begin
        if (std_sec == `RTC_SEC_MAX) begin
          std_sec <= '0;
          if (std_mod == `RTC_MIN_PER_DAY - 11'h001) begin
            std_mod  <= '0;
            std_date <= roll_date;                            // RL1
          end else begin
            std_mod <= std_mod + 11'h001;
          end
        end else begin
          std_sec <= std_sec + 6'h01;
        end
      end
    end
  end

  // validity: set by any accepted write, lost with the backup supply
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clock_valid    <= 1'b0;
      write_rejected <= 1'b0;
    end else if (ce) begin
      if (load) begin
        clock_valid <= 1'b1;                                  // RL18
      end else if (battery_dead) begin
        clock_valid <= 1'b0;                                  // RL10
      end
      write_rejected <= (set_we && !sw_ok) || (ntp_we && !ntp_ok);
    end
  end

  // ----------------------------------------------------------------------
  // daylight saving and local time
  // ----------------------------------------------------------------------
  logic [11:0] loc_sum;  // standard minute plus saving offset
  logic        eu_past;  // at or after the month's last sunday 2:00
  logic        eu_on;    // european saving period

  rtc_wday u_std_wd (.date(std_date), .wday(std_wd));

  always_comb begin
    loc_sum = {1'b0, std_mod};
    if (dst_active) begin
      loc_sum = loc_sum + 12'(11'(dst_qh) * `RTC_QH_MIN);    // RL4
    end
    eu_past = (std_date.day >= 5'(std_wd) + `RTC_LAST_SUN_DAY)
      && (std_wd != `RTC_SUNDAY || std_mod >= `RTC_EU_SWITCH);
    eu_on = (std_date.month >= `RTC_APR && std_date.month <= `RTC_SEP)
      || (std_date.month == `RTC_MAR && eu_past)              // RL6
      || (std_date.month == `RTC_OCT && !eu_past);            // RL7
  end

  // local minute and date with midnight carry
  assign loc_mod  = (loc_sum >= {1'b0, `RTC_MIN_PER_DAY})
                  ? 11'(loc_sum - {1'b0, `RTC_MIN_PER_DAY}) : loc_sum[10:0];
  assign loc_date = (loc_sum >= {1'b0, `RTC_MIN_PER_DAY})
                  ? roll_date : std_date;

  rtc_wday u_loc_wd (.date(loc_date), .wday(loc_wd));          // RL3

  // saving state per mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dst_active <= 1'b0;
    end else if (ce) begin
      case (dst_mode)
        RTC_DST_OFF: dst_active <= 1'b0;                      // RL5
        RTC_DST_ON:  dst_active <= 1'b1;                      // RL5
        RTC_DST_EU:  dst_active <= eu_on;                     // RL6
        RTC_DST_CAL: begin
          if (dst_on_evt) begin
            dst_active <= 1'b1;                               // RL8
          end else if (dst_off_evt) begin
            dst_active <= 1'b0;                               // RL8
          end
        end
        default:     dst_active <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // weekly windows, minute resolution on local time
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < 3; g++) begin : g_win
    logic [10:0] s_m;  // window start
    logic [10:0] e_m;  // window end
    logic [11:0] e_s;  // start plus duration
    assign s_m = sched_cfg[g].start;
    assign e_s = {1'b0, s_m} + {1'b0, sched_cfg[g].stop};
    if (g == 0) begin : g_dur
      assign e_m = (e_s >= {1'b0, `RTC_MIN_PER_DAY})
                 ? 11'(e_s - {1'b0, `RTC_MIN_PER_DAY}) : e_s[10:0]; // RL12
    end else begin : g_end
      assign e_m = sched_cfg[g].stop;
    end
    assign win[g] = sched_cfg[g].day_mask[loc_wd]             // RL17
      && ((s_m <= e_m) ? (loc_mod >= s_m && loc_mod < e_m)
                       : (loc_mod >= s_m || loc_mod < e_m));
  end

  // test abort latch, cleared when the window closes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      test_aborted <= 1'b0;
    end else if (ce) begin
      if (test_mode && grid_fail) begin
        test_aborted <= 1'b1;                                 // RL13
      end else if (!win[0]) begin
        test_aborted <= 1'b0;
      end
    end
  end

  // registered mode requests and clock state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      test_mode             <= 1'b0;
      generator_breaker     <= 1'b0;
      start_inhibit         <= 1'b0;
      remote_start          <= 1'b0;
      clock_invalid_warning <= 1'b0;
      is_clock_master       <= 1'b0;
      // reset date kept legal so range checks hold across release
      local_time            <= '{date: '{7'h00, `RTC_JAN, `RTC_DAY_MIN},
                                 hour: 5'h00, minute: 6'h00, second: 6'h00};
      weekday               <= '0;
    end else if (ce) begin
      test_mode <= sched_en[0] && win[0] && !grid_fail
                   && !test_aborted;                          // RL12 RL13
      generator_breaker <= sched_en[0] && win[0] && !grid_fail
                   && !test_aborted && load_on_test;          // RL14
      start_inhibit <= sched_en[1] && !win[1];                // RL15
      remote_start  <= sched_en[2] && win[2];                 // RL16
      clock_invalid_warning <= !clock_valid && (sched_en != 3'h0); // RL10
      is_clock_master <= master_now;                          // RL11
      local_time <= '{date: loc_date,
                      hour: 5'(loc_mod / `RTC_MIN_PER_HOUR),
                      minute: 6'(loc_mod % `RTC_MIN_PER_HOUR),
                      second: std_sec};
      weekday <= loc_wd;                                      // RL3
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  valid_on_write_a: assert property (ce && sw_ok |=> clock_valid) // RL18
    else $error("clock not valid after accepted write");
  warn_raise_a: assert property (                             // RL10
    ce && !clock_valid && sched_en != 3'h0 |=> clock_invalid_warning)
    else $error("invalid clock warning missing");
  time_range_a: assert property (local_time.hour <= `RTC_HOUR_MAX // RL2
    && local_time.minute <= `RTC_MIN_MAX && local_time.second <= `RTC_SEC_MAX)
    else $error("time field out of range");
  date_range_a: assert property (                             // RL1
    local_time.date.month >= `RTC_MONTH_MIN
    && local_time.date.month <= `RTC_MONTH_MAX
    && local_time.date.day >= `RTC_DAY_MIN)
    else $error("date field out of range");
  breaker_gate_a: assert property (                           // RL14
    generator_breaker |-> test_mode && $past(load_on_test))
    else $error("breaker closed without test load enable");
  grid_abort_a: assert property (                             // RL13
    ce && test_mode && grid_fail |=> !test_mode [*2])
    else $error("test not aborted on grid failure");
  dst_fixed_a: assert property (                              // RL5
    ce && dst_mode == RTC_DST_OFF |=> !dst_active)
    else $error("saving active in fixed-off mode");
  inhibit_en_a: assert property (                             // RL15
    start_inhibit |-> $past(sched_en[1]) && !$past(win[1]))
    else $error("start inhibit outside its rule");
  override_a: assert property (                               // RL16
    ce && sched_en[2] && win[2] |=> remote_start)
    else $error("override window missed");

  test_run_c: cover property (test_mode ##1 !test_mode);
  dst_switch_c: cover property (!dst_active ##1 dst_active);
  ntp_load_c: cover property (ce && ntp_ok ##1 clock_valid);
endmodule : rtc_top

`default_nettype wire

// [rtc_srv_model.sv]
// rtc_srv_model.sv: network time server and bus master peer
// assumes: send is called by the bench, strobes one cycle long
`default_nettype none
module rtc_srv_model
  import rtc_pkg::*;
(
  // clock
  input  wire logic clk,
  // server and bus time out
  output logic      ntp_we,
  output rtc_time_s ntp_utc,
  output logic      bus_we,
  output rtc_time_s bus_time
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {ntp_we, bus_we, ntp_utc, bus_time} = '0;
  // one strobe, then stale fields inverted so they always differ from the sent time
  task automatic send(input logic is_bus, input rtc_time_s t);
    @(posedge clk);
    if (is_bus) {bus_we, bus_time} <= {1'b1, t};
    else {ntp_we, ntp_utc} <= {1'b1, t};
    @(posedge clk);
    {bus_we, ntp_we} <= 2'h0;
    {bus_time, ntp_utc} <= {~t, ~t};
  endtask : send
endmodule : rtc_srv_model
`default_nettype wire

// [tb_rtc_calendar_dst_scheduler.sv]
// tb_rtc_calendar_dst_scheduler.sv: self-checking bench of rtc_top
// assumes: rtc_pkg compiled first, seconds shortened to 20 cycles
`default_nettype none
module tb_rtc_calendar_dst_scheduler;
  import rtc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, arst_n = 0, ce = 1, set_we = 0, battery_dead = 0;
  logic own_is_mains = 1, mains_seen = 1, load_on_test = 1, grid_fail = 0;
  logic dst_on_evt = 0, dst_off_evt = 0, ntp_we, bus_we;
  logic [7:0] own_addr = 8'h05, lowest_mains_addr = 8'h03;
  logic [7:0] lowest_gen_addr = 8'h05;
  logic [3:0] dst_qh = 4'h4;
  logic [2:0] sched_en = 3'h0, weekday;
  logic signed [6:0] tz_qh = 7'sh04;
  rtc_dst_e dst_mode = RTC_DST_OFF;
  rtc_time_s set_time = '0, ntp_utc, bus_time, local_time;
  rtc_sch_s [2:0] sched_cfg = '0;
  logic dst_active, clock_valid, write_rejected, is_clock_master;
  logic clock_invalid_warning, test_mode, generator_breaker;
  logic start_inhibit, remote_start, seen;
  int n_mismatch = 0, n_compared = 0;
  rtc_top #(.TICKS_PER_SEC(20)) i_rtc_top (.*);
  rtc_srv_model i_rtc_srv_model (.clk(clk), .ntp_we(ntp_we),
    .ntp_utc(ntp_utc), .bus_we(bus_we), .bus_time(bus_time));
  always #5 clk = ~clk;
  function automatic rtc_time_s mk(input int y, mo, d, h, mi, s);
    mk = {y[6:0], mo[3:0], d[4:0], h[4:0], mi[5:0], s[5:0]};
  endfunction : mk
  task automatic chk(input logic [35:0] g, e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // software write, answer visible one edge after the take
  task automatic put(input rtc_time_s t);
    @(posedge clk) {set_we, set_time} <= {1'b1, t};
    @(posedge clk) set_we <= 1'b0;
    step(3);
  endtask : put
  task automatic t_valid;
    @(posedge clk) sched_en <= 3'h2;
    step(3);
    chk(clock_valid, 0);
    chk(clock_invalid_warning, 1);
    put(mk(24, 1, 7, 10, 30, 0));
    chk(clock_invalid_warning, 0);
    @(posedge clk) battery_dead <= 1'b1;
    step(3);
    chk({clock_valid, clock_invalid_warning}, 1);
    @(posedge clk) battery_dead <= 1'b0;
    $display("t_valid done");
  endtask : t_valid
  task automatic t_set;
    put(mk(24, 1, 7, 10, 30, 0));
    chk(local_time, mk(24, 1, 7, 10, 30, 0));
    chk({clock_valid, weekday}, 4'h8);
    @(posedge clk) {set_we, set_time} <= {1'b1, mk(24, 13, 7, 10, 0, 0)};
    @(posedge clk) set_we <= 1'b0;
    seen = 0;
    repeat (3) begin
      #1;
      seen |= write_rejected;
      @(posedge clk);
    end
    #1;
    chk(seen, 1);
    chk(local_time, mk(24, 1, 7, 10, 30, 0));
    put(mk(24, 2, 28, 23, 59, 59));
    step(21);
    chk({local_time, weekday}, {mk(24, 2, 29, 0, 0, 0), 3'h4});
    $display("t_set done");
  endtask : t_set
  task automatic t_dst;
    put(mk(24, 1, 7, 10, 30, 0));
    @(posedge clk) dst_mode <= RTC_DST_ON;
    step(3);
    chk({dst_active, local_time.hour}, {1'b1, 5'h0B});
    @(posedge clk) dst_mode <= RTC_DST_OFF;
    step(3);
    chk({dst_active, local_time.hour}, {1'b0, 5'h0A});
    @(posedge clk) dst_mode <= RTC_DST_CAL;
    @(posedge clk) dst_on_evt <= 1'b1;
    @(posedge clk) dst_on_evt <= 1'b0;
    step(3);
    chk(dst_active, 1);
    @(posedge clk) dst_off_evt <= 1'b1;
    @(posedge clk) dst_off_evt <= 1'b0;
    step(3);
    chk(dst_active, 0);
    @(posedge clk) dst_mode <= RTC_DST_EU;
    put(mk(24, 3, 31, 1, 59, 58));
    chk(dst_active, 0);
    step(60);
    chk({dst_active, local_time.hour}, {1'b1, 5'h03});
    put(mk(24, 10, 27, 1, 59, 58));
    chk(dst_active, 1);
    step(60);
    chk({dst_active, local_time.hour}, {1'b0, 5'h02});
    @(posedge clk) dst_mode <= RTC_DST_OFF;
    $display("t_dst done");
  endtask : t_dst
  task automatic t_ntp;
    i_rtc_srv_model.send(0, mk(24, 1, 7, 23, 30, 0));
    step(2);
    chk({local_time, weekday}, {mk(24, 1, 8, 0, 30, 0), 3'h1});
    @(posedge clk) tz_qh <= -7'sh3C;
    i_rtc_srv_model.send(0, mk(24, 1, 8, 12, 0, 0));
    step(2);
    chk(local_time, mk(24, 1, 8, 0, 15, 0));
    $display("t_ntp done");
  endtask : t_ntp
  task automatic t_master;
    @(posedge clk) lowest_mains_addr <= 8'h05;
    step(3);
    chk(is_clock_master, 1);
    i_rtc_srv_model.send(1, mk(24, 1, 7, 10, 30, 0));
    step(2);
    chk(local_time.date, mk(24, 1, 8, 0, 0, 0) >> 17);
    @(posedge clk) lowest_mains_addr <= 8'h03;
    step(3);
    chk(is_clock_master, 0);
    i_rtc_srv_model.send(1, mk(24, 1, 7, 10, 30, 0));
    step(2);
    chk(local_time, mk(24, 1, 7, 10, 30, 0));
    @(posedge clk) {mains_seen, own_is_mains} <= 2'h0;
    step(3);
    chk(is_clock_master, 1);
    $display("t_master done");
  endtask : t_master
  task automatic t_sched;
    @(posedge clk) begin
      sched_cfg <= {{7'h01, 11'h258, 11'h2BC}, {7'h01, 11'h258, 11'h2BC},
                    {7'h01, 11'h258, 11'h03C}};
      sched_en <= 3'h7;
    end
    step(3);
    chk({test_mode, generator_breaker, start_inhibit, remote_start},
        4'hD);
    @(posedge clk) {sched_cfg[1].day_mask, load_on_test} <= {7'h02, 1'b0};
    step(3);
    chk({generator_breaker, start_inhibit}, 2'h1);
    @(posedge clk) grid_fail <= 1'b1;
    step(3);
    chk(test_mode, 0);
    @(posedge clk) grid_fail <= 1'b0;
    step(3);
    chk(test_mode, 0);
    $display("t_sched done");
  endtask : t_sched
  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_valid();
    t_set();
    t_dst();
    t_ntp();
    t_master();
    t_sched();
    final_report();
  end
endmodule : tb_rtc_calendar_dst_scheduler
`default_nettype wire
